/* File: rtl/pallet_seq_pkg.sv */
// Purpose: Shared constants and types of the palletizing run sequencer.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave.
// Notes: Speeds are unsigned 16-bit units; override is in percent.
package pallet_seq_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned PWR_WAIT_S = 5;
  localparam int unsigned PWR_WAIT_CYC = PWR_WAIT_S * CLK_HZ;
  localparam int unsigned BOOT_SETTLE_CYC = 4;
  localparam int unsigned CNT_W = 28;
  localparam int unsigned AW = 5;
  localparam logic [AW-1:0] ADDR_CTRL = 5'h00;
  localparam logic [AW-1:0] ADDR_OVR = 5'h04;
  localparam logic [AW-1:0] ADDR_MAXSPD = 5'h08;
  localparam logic [AW-1:0] ADDR_STATUS = 5'h0c;
  localparam int unsigned CTRL_PAL_OK_BIT = 0;
  localparam int unsigned CTRL_READY_EN_BIT = 1;
  localparam logic CTRL_PAL_OK_RST = 1'b1;
  localparam logic CTRL_READY_EN_RST = 1'b0;
  localparam int unsigned STAT_ERR_BIT = 9;
  localparam int unsigned OVR_W = 7;
  localparam logic [OVR_W-1:0] OVR_FULL = 7'h64;
  localparam int unsigned SPD_W = 16;
  localparam logic [SPD_W-1:0] MAXSPD_RST = 16'hffff;
  localparam int unsigned PROD_W = SPD_W + OVR_W;
  localparam int unsigned NIN = 7;
  localparam int unsigned IN_START = 0;
  localparam int unsigned IN_STOP = 1;
  localparam int unsigned IN_RESET = 2;
  localparam int unsigned IN_PAL = 3;
  localparam int unsigned IN_SINGLE = 4;
  localparam int unsigned IN_CONT = 5;
  localparam int unsigned IN_HOME = 6;
  typedef enum logic [4:0] {
    ST_BOOT = 5'h01,
    ST_IDLE = 5'h02,
    ST_RUN = 5'h04,
    ST_PAUSE = 5'h08,
    ST_HALT = 5'h10
  } state_t;
endpackage

/* File: rtl/pallet_run_mode_sequencer.sv */
// Purpose: Run control of a stored palletizing program.
// Assumes: An executor reports each finished instruction and program end.
// Notes: Contract list follows.
// Contract
// - Start launches only with palletizing select high.
// - Start input ignored while pendant active.
// - Palletizing select ignored unless sequential mode.
// - Stop finishes current operation, then halts.
// - Start resumes halt; reset then start restarts.
// - Without ready output, accept inputs after five seconds.
// - Single operation pauses after each operation.
// - Single-operation drop during single run ignored.
// - Single-operation rise during continuous run ignored.
// - Only movement, homing, output instructions pause.
// - Start-input launch always runs automatic mode.
// - Pendant step key executes one step, halts.
// - Override changes accepted only while halted; code also accepts them in idle and pause, dropping them only in run and boot.
// - Override value kept in nonvolatile storage.
// - Override also scales jog and fast homing.
// - Override scales speed after maximum clamp.
// - Power-up resume only after clean halt.
// - Unclean halt refuses resume, raises error.
// - Resume input otherwise general-purpose input.
// - Emergency stop halt still allows resume.
//
// Added by the designer: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pallet_run_mode_sequencer #(
  parameter int unsigned PWR_WAIT_CYCLES = pallet_seq_pkg::PWR_WAIT_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [pallet_seq_pkg::AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic start_in,
  input wire logic stop_in,
  input wire logic reset_in,
  input wire logic pallet_sel_in,
  input wire logic single_op_in,
  input wire logic cont_start_in,
  input wire logic home_req_in,
  input wire logic pendant_active_in,
  input wire logic pendant_start_key_in,
  input wire logic step_mode_in,
  input wire logic instr_done_in,
  input wire logic pause_point_in,
  input wire logic program_end_in,
  input wire logic stop_instr_in,
  input wire logic fault_in,
  input wire logic estop_in,
  input wire logic home_done_in,
  input wire logic nv_resume_ok_in,
  input wire logic [pallet_seq_pkg::OVR_W-1:0] nv_override_in,
  input wire logic [pallet_seq_pkg::SPD_W-1:0] speed_cmd_in,
  output logic ready_out,
  output logic run_out,
  output logic step_adv_out,
  output logic restart_top_out,
  output logic home_cmd_out,
  output logic gp_cont_start_out,
  output logic nv_resume_ok_out,
  output logic [pallet_seq_pkg::OVR_W-1:0] nv_override_out,
  output logic [pallet_seq_pkg::SPD_W-1:0] speed_out
);
  import pallet_seq_pkg::*;

  logic [NIN-1:0] din;
  logic [NIN-1:0] lvl;
  logic [NIN-1:0] rise;
  state_t state_ff;
  state_t nxt_state;
  logic [CNT_W-1:0] boot_cnt_ff;
  logic ctrl_pal_ok_ff;
  logic ctrl_ready_en_ff;
  logic [OVR_W-1:0] ovr_ff;
  logic [SPD_W-1:0] maxspd_ff;
  logic [SPD_W-1:0] speed_ff;
  logic single_ff;
  logic step_ff;
  logic stop_pend_ff;
  logic err_ff;
  logic resume_ok_ff;
  logic ready_ff;
  logic run_ff;
  logic step_adv_ff;
  logic restart_ff;
  logic home_cmd_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] rd_mux;
  logic [31:0] status_w;
  logic wr_hit;
  logic boot_done;
  logic resume_req;
  logic start_ext;
  logic pallet_ok;
  logic launch;
  logic go_ev;
  logic reset_ev;
  logic halt_now;
  logic pause_now;
  logic [SPD_W-1:0] clamp_spd;
  logic [PROD_W-1:0] prod;
  logic [PROD_W-1:0] scaled;

  assign din[IN_START] = start_in;
  assign din[IN_STOP] = stop_in;
  assign din[IN_RESET] = reset_in;
  assign din[IN_PAL] = pallet_sel_in;
  assign din[IN_SINGLE] = single_op_in;
  assign din[IN_CONT] = cont_start_in;
  assign din[IN_HOME] = home_req_in;

  // Two-stage synchroniser, edge from second stage.
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_sync
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
        end else begin
          s1_ff <= din[gi];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
        end
      end
      assign lvl[gi] = s2_ff;
      assign rise[gi] = s2_ff & ~s3_ff;
    end
  endgenerate

  assign start_ext = rise[IN_START] & ~pendant_active_in;
  // Select only counts in sequential mode.
  assign pallet_ok = ctrl_pal_ok_ff & lvl[IN_PAL];
  assign launch = (start_ext & pallet_ok) | pendant_start_key_in;
  assign go_ev = start_ext | pendant_start_key_in;
  assign reset_ev = rise[IN_RESET];
  // Stop waits for the current operation.
  // Step run halts after one step.
  assign halt_now = stop_instr_in | fault_in | estop_in
                    | (instr_done_in & (stop_pend_ff | step_ff));
  assign pause_now = instr_done_in & single_ff & pause_point_in;
  // Resume input doubles as a plain input.
  assign gp_cont_start_out = lvl[IN_CONT];
  assign resume_req = lvl[IN_CONT];

  assign boot_done = (state_ff == ST_BOOT) &&
    (ctrl_ready_en_ff ? (boot_cnt_ff >= CNT_W'(BOOT_SETTLE_CYC - 1))
                      : (boot_cnt_ff == CNT_W'(PWR_WAIT_CYCLES - 1)));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_cnt_ff <= '0;
    end else if (state_ff == ST_BOOT && !boot_done) begin
      boot_cnt_ff <= boot_cnt_ff + CNT_W'(1);
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_BOOT: begin
        // Resume only after a clean halt.
        if (boot_done) begin
          nxt_state = (resume_req & nv_resume_ok_in) ? ST_RUN : ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (launch) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (program_end_in) begin
          nxt_state = ST_IDLE;
        end else if (halt_now) begin
          nxt_state = ST_HALT;
        end else if (pause_now) begin
          nxt_state = ST_PAUSE;
        end
      end
      ST_PAUSE, ST_HALT: begin
        if (reset_ev) begin
          nxt_state = ST_IDLE;
        end else if (go_ev) begin
          nxt_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_BOOT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Mode fixed for the whole run.
  // Mode inputs read only at boot end, launch and resume.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      single_ff <= 1'b0;
      step_ff <= 1'b0;
    end else if (state_ff == ST_BOOT && boot_done) begin
      single_ff <= lvl[IN_SINGLE];
      step_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && launch) begin
      single_ff <= lvl[IN_SINGLE];
      step_ff <= ~start_ext & step_mode_in;
    end else if ((state_ff == ST_HALT || state_ff == ST_PAUSE) && go_ev && !reset_ev) begin
      step_ff <= ~start_ext & step_mode_in;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_pend_ff <= 1'b0;
    end else if (state_ff != ST_RUN || nxt_state != ST_RUN) begin
      stop_pend_ff <= 1'b0;
    end else if (rise[IN_STOP]) begin
      stop_pend_ff <= 1'b1;
    end
  end

  // Emergency stop counts as clean halt.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resume_ok_ff <= 1'b0;
    end else if (state_ff == ST_RUN) begin
      if (nxt_state == ST_HALT) begin
        resume_ok_ff <= ~fault_in;
      end else if (nxt_state == ST_PAUSE) begin
        resume_ok_ff <= 1'b1;
      end else begin
        resume_ok_ff <= 1'b0;
      end
    end else if (nxt_state == ST_IDLE) begin
      resume_ok_ff <= 1'b0;
    end
  end

  // Refused resume raises the error; set beats clear.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_ff <= 1'b0;
    end else if (boot_done && resume_req && !nv_resume_ok_in) begin
      err_ff <= 1'b1;
    end else if (wr_hit && avs_address == ADDR_STATUS && avs_byteenable[1]
                 && avs_writedata[STAT_ERR_BIT]) begin
      err_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ready_ff <= 1'b0;
      run_ff <= 1'b0;
      step_adv_ff <= 1'b0;
      restart_ff <= 1'b0;
      home_cmd_ff <= 1'b0;
    end else begin
      ready_ff <= ctrl_ready_en_ff & (nxt_state != ST_BOOT);
      run_ff <= (nxt_state == ST_RUN);
      step_adv_ff <= (state_ff == ST_RUN) & instr_done_in & step_ff & ~program_end_in;
      restart_ff <= (state_ff == ST_HALT || state_ff == ST_PAUSE) & reset_ev;
      home_cmd_ff <= rise[IN_HOME] & (state_ff != ST_RUN) & (state_ff != ST_BOOT);
    end
  end

  // Clamp to the maximum before scaling.
  // One path serves program, jog and homing speeds.
  assign clamp_spd = (speed_cmd_in > maxspd_ff) ? maxspd_ff : speed_cmd_in;
  assign prod = PROD_W'(clamp_spd) * PROD_W'(ovr_ff);
  assign scaled = prod / PROD_W'(OVR_FULL);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_ff <= '0;
    end else begin
      speed_ff <= scaled[SPD_W-1:0];
    end
  end

  assign wr_hit = avs_write & ack_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_pal_ok_ff <= CTRL_PAL_OK_RST;
      ctrl_ready_en_ff <= CTRL_READY_EN_RST;
    end else if (wr_hit && avs_address == ADDR_CTRL && avs_byteenable[0]) begin
      ctrl_pal_ok_ff <= avs_writedata[CTRL_PAL_OK_BIT];
      ctrl_ready_en_ff <= avs_writedata[CTRL_READY_EN_BIT];
    end
  end

  // Override restored from nonvolatile copy at boot.
  // Writes during a run are dropped.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovr_ff <= OVR_FULL;
    end else if (boot_done) begin
      ovr_ff <= (nv_override_in > OVR_FULL) ? OVR_FULL : nv_override_in;
    end else if (wr_hit && avs_address == ADDR_OVR && avs_byteenable[0]
                 && state_ff != ST_RUN && state_ff != ST_BOOT) begin
      ovr_ff <= (avs_writedata[OVR_W-1:0] > OVR_FULL) ? OVR_FULL : avs_writedata[OVR_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      maxspd_ff <= MAXSPD_RST;
    end else if (wr_hit && avs_address == ADDR_MAXSPD) begin
      if (avs_byteenable[0]) begin
        maxspd_ff[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        maxspd_ff[SPD_W-1:8] <= avs_writedata[SPD_W-1:8];
      end
    end
  end

  assign status_w = {20'h0, resume_ok_ff, home_done_in, err_ff, ready_ff,
                     stop_pend_ff, step_ff, single_ff, state_ff};

  always_comb begin
    rd_mux = 32'h0;
    unique case (avs_address)
      ADDR_CTRL: rd_mux = 32'({ctrl_ready_en_ff, ctrl_pal_ok_ff});
      ADDR_OVR: rd_mux = 32'(ovr_ff);
      ADDR_MAXSPD: rd_mux = 32'(maxspd_ff);
      ADDR_STATUS: rd_mux = status_w;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_ff <= 32'h0;
    end else if (avs_read && !ack_ff) begin
      rdata_ff <= rd_mux;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata = rdata_ff;
  assign ready_out = ready_ff;
  assign run_out = run_ff;
  assign step_adv_out = step_adv_ff;
  assign restart_top_out = restart_ff;
  assign home_cmd_out = home_cmd_ff;
  assign nv_resume_ok_out = resume_ok_ff;
  assign nv_override_out = ovr_ff;
  assign speed_out = speed_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  boot_wait_a: assert property ($fell(state_ff == ST_BOOT) && !$past(ctrl_ready_en_ff)
    |-> $past(boot_cnt_ff) == CNT_W'(PWR_WAIT_CYCLES - 1))
    else $error("Boot ended before the power-up wait.");
  pal_gate_a: assert property (state_ff == ST_IDLE && rise[IN_START] && !pallet_ok
    && !pendant_start_key_in |=> state_ff == ST_IDLE)
    else $error("Start launched without palletizing select.");
  mode_gate_a: assert property (state_ff == ST_IDLE && !ctrl_pal_ok_ff
    && !pendant_start_key_in |=> state_ff == ST_IDLE)
    else $error("Select honoured outside sequential mode.");
  pend_ign_a: assert property (state_ff == ST_HALT && pendant_active_in && !pendant_start_key_in
    && !reset_ev |=> state_ff == ST_HALT)
    else $error("Start input acted with pendant active.");
  stop_fin_a: assert property (state_ff == ST_RUN && rise[IN_STOP] && !halt_now
    && !pause_now && !program_end_in |=> state_ff == ST_RUN && stop_pend_ff)
    else $error("Stop did not wait for the operation.");
  resume_a: assert property (state_ff == ST_HALT && go_ev && !reset_ev
    |=> state_ff == ST_RUN)
    else $error("Start did not resume a halt.");
  restart_a: assert property (state_ff == ST_HALT && reset_ev
    |=> state_ff == ST_IDLE && restart_top_out)
    else $error("Reset did not restart from the top.");
  pause_pt_a: assert property (state_ff == ST_RUN && pause_now && !halt_now
    && !program_end_in |=> state_ff == ST_PAUSE)
    else $error("Single operation did not pause.");
  no_pause_a: assert property (state_ff == ST_RUN && instr_done_in && !pause_point_in
    && !halt_now && !program_end_in |=> state_ff == ST_RUN)
    else $error("Non-pause instruction stopped the run.");
  mode_hold_a: assert property (state_ff == ST_RUN && $past(state_ff) == ST_RUN
    |-> $stable(single_ff))
    else $error("Run mode changed during a run.");
  auto_start_a: assert property (state_ff == ST_IDLE && start_ext && pallet_ok
    |=> state_ff == ST_RUN && !step_ff)
    else $error("Start-input launch entered step mode.");
  step_one_a: assert property (state_ff == ST_RUN && instr_done_in && step_ff
    && !program_end_in |=> state_ff == ST_HALT && step_adv_out)
    else $error("Step run did not halt after one step.");
  ovr_lock_a: assert property ($changed(ovr_ff) |-> $past(state_ff) != ST_RUN)
    else $error("Override changed during a run.");
  spd_clamp_a: assert property (##1 speed_out <= $past(maxspd_ff))
    else $error("Scaled speed exceeds the maximum.");
  refuse_a: assert property (boot_done && resume_req && !nv_resume_ok_in
    |=> err_ff && state_ff == ST_IDLE)
    else $error("Unclean resume was not refused.");

  launch_c: cover property (state_ff == ST_IDLE && start_ext && pallet_ok);
  pause_c: cover property (state_ff == ST_PAUSE ##1 state_ff == ST_RUN);
  step_c: cover property (step_adv_out);
  refuse_c: cover property (boot_done && resume_req && !nv_resume_ok_in);
endmodule // pallet_run_mode_sequencer
`default_nettype wire

/* File: sim/host_model.sv */
// Purpose: Host controller model driving the discrete control inputs of the sequencer.
// Assumes: The sequencer synchronises these levels over two clock edges.
// Notes: A press holds its level for four cycles, then releases it for four.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic ready_out,
  input wire logic home_done_in,
  output logic start_in,
  output logic stop_in,
  output logic reset_in,
  output logic home_req_in,
  output logic pallet_sel_in,
  output logic single_op_in,
  output logic cont_start_in
);
  initial begin
    {start_in, stop_in, reset_in, home_req_in} = 4'h0;
    {pallet_sel_in, single_op_in, cont_start_in} = 3'h0;
  end

  task automatic drive(input int idx, input logic v);
    case (idx)
      0: start_in <= v;
      1: stop_in <= v;
      2: reset_in <= v;
      3: home_req_in <= v;
      4: pallet_sel_in <= v;
      5: single_op_in <= v;
      default: cont_start_in <= v;
    endcase
  endtask

  task automatic press(input int idx);
    @(posedge clk);
    drive(idx, 1'b1);
    repeat (4) @(posedge clk);
    drive(idx, 1'b0);
    repeat (4) @(posedge clk);
  endtask

  task automatic wait_ready(output logic ok);
    int n;
    n = 0;
    while (ready_out !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    ok = (ready_out === 1'b1);
  endtask

  task automatic home(output logic ok);
    int n;
    press(3);
    n = 0;
    while (home_done_in !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    ok = (home_done_in === 1'b1);
  endtask
endmodule // host_model
`default_nettype wire

/* File: sim/pallet_run_mode_sequencer_bench.sv */
// Purpose: Self-checking bench of the palletizing run sequencer.
// Assumes: The power-up wait is shortened to BOOT_N cycles.
// Notes: Executor, pendant and bus are driven here; host levels by the host model.
`timescale 1ns/1ps
`default_nettype none
module pallet_run_mode_sequencer_bench;
  import pallet_seq_pkg::*;
  localparam int unsigned BOOT_N = 50;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [AW-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic start_in, stop_in, reset_in, pallet_sel_in, single_op_in, cont_start_in, home_req_in;
  logic pendant_active_in = 1'b0;
  logic pendant_start_key_in = 1'b0;
  logic step_mode_in = 1'b0;
  logic instr_done_in = 1'b0;
  logic pause_point_in = 1'b0;
  logic program_end_in = 1'b0;
  logic stop_instr_in = 1'b0;
  logic fault_in = 1'b0;
  logic estop_in = 1'b0;
  logic home_done_in = 1'b0;
  logic nv_resume_ok_in = 1'b0;
  logic [OVR_W-1:0] nv_override_in = OVR_FULL;
  logic [SPD_W-1:0] speed_cmd_in = 16'h07d0;
  logic ready_out, run_out, step_adv_out, restart_top_out, home_cmd_out;
  logic gp_cont_start_out, nv_resume_ok_out;
  logic [OVR_W-1:0] nv_override_out;
  logic [SPD_W-1:0] speed_out;
  int err_total = 0;
  int comparisons = 0;
  int steps = 0;
  int restarts = 0;
  int homes = 0;
  logic [31:0] q;
  logic ok;

  pallet_run_mode_sequencer #(.PWR_WAIT_CYCLES(BOOT_N)) u_pallet_run_mode_sequencer (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .start_in(start_in),
    .stop_in(stop_in), .reset_in(reset_in), .pallet_sel_in(pallet_sel_in),
    .single_op_in(single_op_in), .cont_start_in(cont_start_in), .home_req_in(home_req_in),
    .pendant_active_in(pendant_active_in), .pendant_start_key_in(pendant_start_key_in),
    .step_mode_in(step_mode_in), .instr_done_in(instr_done_in),
    .pause_point_in(pause_point_in), .program_end_in(program_end_in),
    .stop_instr_in(stop_instr_in), .fault_in(fault_in), .estop_in(estop_in),
    .home_done_in(home_done_in), .nv_resume_ok_in(nv_resume_ok_in),
    .nv_override_in(nv_override_in), .speed_cmd_in(speed_cmd_in), .ready_out(ready_out),
    .run_out(run_out), .step_adv_out(step_adv_out), .restart_top_out(restart_top_out),
    .home_cmd_out(home_cmd_out), .gp_cont_start_out(gp_cont_start_out),
    .nv_resume_ok_out(nv_resume_ok_out), .nv_override_out(nv_override_out),
    .speed_out(speed_out));

  host_model u_host_model (
    .clk(clk), .ready_out(ready_out), .home_done_in(home_done_in), .start_in(start_in),
    .stop_in(stop_in), .reset_in(reset_in), .home_req_in(home_req_in),
    .pallet_sel_in(pallet_sel_in), .single_op_in(single_op_in),
    .cont_start_in(cont_start_in));

  always #10 clk = ~clk;

  always @(posedge clk) begin
    if (step_adv_out === 1'b1) steps++;
    if (restart_top_out === 1'b1) restarts++;
    if (home_cmd_out === 1'b1) homes++;
    if (home_cmd_out === 1'b1) home_done_in <= 1'b1;
  end

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic lost();
    err_total++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic w, input logic [AW-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
      if (n > 20) lost();
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [AW-1:0] a);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic st(input state_t s);
    rd(ADDR_STATUS);
    chk(q[4:0], s);
  endtask

  task automatic done(input logic pp);
    pause_point_in <= pp;
    instr_done_in <= 1'b1;
    @(posedge clk);
    instr_done_in <= 1'b0;
    cyc(3);
  endtask

  task automatic pls(input int k);
    case (k)
      0: stop_instr_in <= 1'b1;
      1: fault_in <= 1'b1;
      2: estop_in <= 1'b1;
      3: pendant_start_key_in <= 1'b1;
      default: program_end_in <= 1'b1;
    endcase
    @(posedge clk);
    stop_instr_in <= 1'b0;
    fault_in <= 1'b0;
    estop_in <= 1'b0;
    pendant_start_key_in <= 1'b0;
    program_end_in <= 1'b0;
    cyc(3);
  endtask

  task automatic boot(input logic fast);
    int n;
    reset_n <= 1'b0;
    cyc(4);
    reset_n <= 1'b1;
    cyc(1);
    n = 0;
    if (fast) begin
      wr(ADDR_CTRL, 32'h3);
      u_host_model.wait_ready(ok);
      chk(ok, 1'b1);
    end else begin
      do begin
        rd(ADDR_STATUS);
        n++;
        if (n > 40) lost();
      end while (q[0] === 1'b1);
    end
  endtask

  task automatic t_boot();
    reset_n <= 1'b1;
    cyc(30);
    st(ST_BOOT);
    chk(ready_out, 1'b0);
    cyc(25);
    st(ST_IDLE);
    rd(ADDR_CTRL);
    chk(q, 32'h1);
    rd(ADDR_OVR);
    chk(q, 32'h64);
    rd(ADDR_MAXSPD);
    chk(q, 32'hffff);
    rd(5'h10);
    chk(q, 32'h0);
    $display("test boot done");
  endtask

  task automatic t_refuse();
    pendant_active_in <= 1'b1;
    u_host_model.drive(4, 1'b1);
    u_host_model.press(0);
    st(ST_IDLE);
    pendant_active_in <= 1'b0;
    u_host_model.drive(4, 1'b0);
    u_host_model.press(0);
    st(ST_IDLE);
    wr(ADDR_CTRL, 32'h0);
    u_host_model.drive(4, 1'b1);
    u_host_model.press(0);
    st(ST_IDLE);
    wr(ADDR_CTRL, 32'h1);
    $display("test refuse done");
  endtask

  task automatic t_single();
    u_host_model.drive(5, 1'b1);
    u_host_model.home(ok);
    chk(ok, 1'b1);
    chk(homes, 1);
    u_host_model.press(0);
    st(ST_RUN);
    chk(run_out, 1'b1);
    done(1'b0);
    st(ST_RUN);
    done(1'b1);
    st(ST_PAUSE);
    chk(run_out, 1'b0);
    u_host_model.drive(5, 1'b0);
    u_host_model.press(0);
    st(ST_RUN);
    done(1'b1);
    st(ST_PAUSE);
    $display("test single done");
  endtask

  task automatic t_cont();
    boot(1'b0);
    step_mode_in <= 1'b1;
    u_host_model.press(0);
    st(ST_RUN);
    chk(q[6], 1'b0);
    u_host_model.drive(5, 1'b1);
    done(1'b1);
    st(ST_RUN);
    chk(steps, 0);
    step_mode_in <= 1'b0;
    u_host_model.drive(5, 1'b0);
    u_host_model.press(1);
    st(ST_RUN);
    chk(q[7], 1'b1);
    done(1'b0);
    st(ST_HALT);
    chk(nv_resume_ok_out, 1'b1);
    wr(ADDR_OVR, 32'h7f);
    rd(ADDR_OVR);
    chk(q, 32'h64);
    wr(ADDR_OVR, 32'h32);
    wr(ADDR_MAXSPD, 32'h3e8);
    rd(ADDR_OVR);
    chk(q, 32'h32);
    chk(nv_override_out, 7'h32);
    chk(speed_out, 16'h01f4);
    speed_cmd_in <= 16'h0190;
    cyc(2);
    chk(speed_out, 16'h00c8);
    u_host_model.press(0);
    st(ST_RUN);
    wr(ADDR_OVR, 32'h10);
    rd(ADDR_OVR);
    chk(q, 32'h32);
    pls(0);
    st(ST_HALT);
    pendant_active_in <= 1'b1;
    u_host_model.press(0);
    st(ST_HALT);
    pendant_active_in <= 1'b0;
    chk(restarts, 0);
    u_host_model.press(2);
    u_host_model.press(0);
    st(ST_RUN);
    chk(restarts, 1);
    pls(2);
    st(ST_HALT);
    chk(nv_resume_ok_out, 1'b1);
    u_host_model.press(0);
    pls(1);
    st(ST_HALT);
    chk(nv_resume_ok_out, 1'b0);
    $display("test continuous done");
  endtask

  task automatic t_step();
    boot(1'b0);
    step_mode_in <= 1'b1;
    pls(3);
    done(1'b0);
    st(ST_HALT);
    chk(steps, 1);
    pls(3);
    done(1'b0);
    st(ST_HALT);
    chk(steps, 2);
    pls(3);
    pls(4);
    st(ST_IDLE);
    chk(steps, 2);
    step_mode_in <= 1'b0;
    $display("test step done");
  endtask

  task automatic t_resume();
    nv_resume_ok_in <= 1'b1;
    nv_override_in <= 7'h20;
    u_host_model.drive(6, 1'b1);
    boot(1'b1);
    st(ST_RUN);
    rd(ADDR_OVR);
    chk(q, 32'h20);
    chk(gp_cont_start_out, 1'b1);
    u_host_model.drive(6, 1'b0);
    cyc(4);
    chk(gp_cont_start_out, 1'b0);
    st(ST_RUN);
    nv_resume_ok_in <= 1'b0;
    u_host_model.drive(6, 1'b1);
    boot(1'b1);
    st(ST_IDLE);
    chk(q[STAT_ERR_BIT], 1'b1);
    avs_byteenable <= 4'h1;
    wr(ADDR_STATUS, 32'h200);
    st(ST_IDLE);
    chk(q[STAT_ERR_BIT], 1'b1);
    avs_byteenable <= 4'hf;
    wr(ADDR_STATUS, 32'h200);
    st(ST_IDLE);
    chk(q[STAT_ERR_BIT], 1'b0);
    u_host_model.drive(6, 1'b0);
    $display("test resume done");
  endtask

  initial begin
    cyc(4);
    t_boot();
    t_refuse();
    t_single();
    t_cont();
    t_step();
    t_resume();
    wrap_up();
  end
endmodule // pallet_run_mode_sequencer_bench
`default_nettype wire
